// File: dcsr_pkg.sv
// Operation
// - control msb of clear field set keeps multiplier input low half on high load.
// - control middle clear bit set keeps accumulator one low half on high load.
// - control lsb of clear field set keeps accumulator zero low half on high load.
// - high-half moves write bits 31..16 (sign-extended through 35..32 on accumulators) and zero the low half when enabled.
// - upper clamp-inhibit bit set stops saturation of accumulator one.
// - lower clamp-inhibit bit set stops saturation of accumulator zero.
// - scaling field: 00 raw, 01 divide by four, 10 times four; 11 reserved.
// - status bits 15..13 report minus, equal and logical overflow flags.
// - status bit 12 reports mathematical overflow of the last result.
// - status bit 9 set means accumulator one overflowed.
// - status bit 4 set means accumulator zero overflowed.
// - status bits 8..5 mirror accumulator one bits 35..32.
// - status bits 3..0 mirror accumulator zero bits 35..32.
// - control register is seven bits, read back zero-extended.
package dcsr_pkg;

   // byte addresses on the register bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PSW = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_Y_HI = 8'h10;
   localparam logic [7:0] OFS_Y_LO = 8'h14;
   localparam logic [7:0] OFS_X = 8'h18;
   localparam logic [7:0] OFS_CMD = 8'h1C;
   localparam logic [7:0] OFS_PROD = 8'h20;
   localparam logic [7:0] OFS_ACC0_HI = 8'h24;
   localparam logic [7:0] OFS_ACC0_LO = 8'h28;
   localparam logic [7:0] OFS_ACC1_HI = 8'h2C;
   localparam logic [7:0] OFS_ACC1_LO = 8'h30;

   // command register bits
   localparam int CMD_MUL_BIT = 0;
   localparam int CMD_ACC_BIT = 1;
   localparam int CMD_DST_BIT = 2;

   // interrupt status / mask bits
   localparam int IRQ_W = 3;
   localparam int IRQ_ACC0_OVF = 0;
   localparam int IRQ_ACC1_OVF = 1;
   localparam int IRQ_MATH_OVF = 2;

   localparam logic [6:0] CTRL_RESET = 7'h00;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
   localparam logic [35:0] ACC_POS_LIMIT = 36'h0_7FFF_FFFF;
   localparam logic [35:0] ACC_NEG_LIMIT = 36'hF_8000_0000;

   typedef enum logic [1:0] {
      DCSR_ALIGN_RAW = 2'b00,
      DCSR_ALIGN_DIV4 = 2'b01,
      DCSR_ALIGN_MUL4 = 2'b10,
      DCSR_ALIGN_RSVD = 2'b11
   } dcsr_align_t;

   typedef struct packed {
      logic [2:0] low_half_zero_inhibit; // [2] y, [1] acc one, [0] acc zero
      logic [1:0] overflow_clamp_inhibit; // [1] acc one, [0] acc zero
      dcsr_align_t align;
   } dcsr_ctrl_t;

   typedef struct packed {
      logic minus_flag;
      logic equal_flag;
      logic logical_overflow_flag;
      logic math_overflow_flag;
      logic [1:0] undefined;
      logic acc1_ovf;
      logic [3:0] acc1_guard;
      logic acc0_ovf;
      logic [3:0] acc0_guard;
   } dcsr_psw_t;

   typedef struct packed {
      logic [35:0] value;
      logic minus;
      logic equal;
      logic lov;
      logic mov;
   } dcsr_acc_res_t;

endpackage

// File: dcsr_regs.sv
`timescale 1ns/100ps
module dcsr_regs
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq
);
   import dcsr_pkg::*;

   dcsr_ctrl_t ctrl;
   logic [31:0] y;
   logic [15:0] x;
   logic [31:0] prod;
   logic [35:0] acc [2];
   logic [3:0] flags;
   logic [1:0] acc_ovf;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;

   logic setup;
   logic wr;
   logic rd;
   logic mul_go;
   logic acc_go;
   logic acc_dst;
   logic signed [31:0] mult_raw;
   logic [31:0] prod_scaled;
   dcsr_acc_res_t acc_res;
   dcsr_psw_t psw_rd;
   dcsr_psw_t psw_wr;
   logic [IRQ_W-1:0] events;
   logic [31:0] next_rdata;
   logic next_err;

   function automatic logic [7:0] hi_ofs(input int i);
      hi_ofs = (i == 1) ? OFS_ACC1_HI : OFS_ACC0_HI;
   endfunction

   function automatic logic [7:0] lo_ofs(input int i);
      lo_ofs = (i == 1) ? OFS_ACC1_LO : OFS_ACC0_LO;
   endfunction

   // reserved code 11 falls back to the raw product
   function automatic logic [31:0] scale_product(input logic signed [31:0] p,
                                                 input dcsr_align_t a);
      case (a)
         DCSR_ALIGN_DIV4: scale_product = p >>> 2;
         DCSR_ALIGN_MUL4: scale_product = p <<< 2;
         default: scale_product = p;
      endcase
   endfunction

   // overflow flags describe the raw sum; minus and equal follow the stored, possibly clamped value
   function automatic dcsr_acc_res_t acc_step(input logic [35:0] a,
                                              input logic [31:0] p,
                                              input logic clamp_off);
      dcsr_acc_res_t r;
      logic [35:0] sum;
      logic true_neg;
      sum = a + {{4{p[31]}}, p};
      r.mov = (a[35] == p[31]) && (sum[35] != a[35]);
      r.lov = r.mov || !((sum[35:31] == 5'h00) || (sum[35:31] == 5'h1F));
      true_neg = r.mov ? ~sum[35] : sum[35];
      if (r.lov && !clamp_off)
      begin
         r.value = true_neg ? ACC_NEG_LIMIT : ACC_POS_LIMIT;
      end
      else
      begin
         r.value = sum;
      end
      r.minus = r.value[35];
      r.equal = (r.value == 36'h0_0000_0000);
      acc_step = r;
   endfunction

   // one wait state: pready rises in the second access cycle
   assign setup = psel && penable && !pready;
   assign wr = psel && penable && pready && pwrite;
   assign rd = psel && penable && pready && !pwrite;
   assign mul_go = wr && (paddr == OFS_CMD) && pwdata[CMD_MUL_BIT];
   assign acc_go = wr && (paddr == OFS_CMD) && pwdata[CMD_ACC_BIT];
   assign acc_dst = pwdata[CMD_DST_BIT];
   assign mult_raw = $signed(x) * $signed(y[31:16]);
   assign prod_scaled = scale_product(mult_raw, ctrl.align);
   assign acc_res = acc_step(acc[acc_dst], prod,
                             ctrl.overflow_clamp_inhibit[acc_dst]);
   assign psw_wr = dcsr_psw_t'(pwdata[15:0]);

   always_comb
   begin
      psw_rd.minus_flag = flags[3];
      psw_rd.equal_flag = flags[2];
      psw_rd.logical_overflow_flag = flags[1];
      psw_rd.math_overflow_flag = flags[0];
      psw_rd.undefined = 2'b00;
      psw_rd.acc1_ovf = acc_ovf[1];
      psw_rd.acc1_guard = acc[1][35:32];
      psw_rd.acc0_ovf = acc_ovf[0];
      psw_rd.acc0_guard = acc[0][35:32];
   end

   always_comb
   begin
      events = '0;
      if (acc_go)
      begin
         events[IRQ_ACC0_OVF] = acc_res.lov && !acc_dst;
         events[IRQ_ACC1_OVF] = acc_res.lov && acc_dst;
         events[IRQ_MATH_OVF] = acc_res.mov;
      end
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (paddr == OFS_CTRL)
         next_rdata = {25'h000_0000, ctrl};
      else if (paddr == OFS_PSW)
         next_rdata = {16'h0000, psw_rd};
      else if (paddr == OFS_IRQ_STAT)
         next_rdata = {29'h0000_0000, irq_stat};
      else if (paddr == OFS_IRQ_MASK)
         next_rdata = {29'h0000_0000, irq_mask};
      else if (paddr == OFS_Y_HI)
         next_rdata = {16'h0000, y[31:16]};
      else if (paddr == OFS_Y_LO)
         next_rdata = {16'h0000, y[15:0]};
      else if (paddr == OFS_X)
         next_rdata = {16'h0000, x};
      else if (paddr == OFS_CMD)
         next_rdata = 32'h0000_0000;
      else if (paddr == OFS_PROD)
         next_rdata = prod;
      else if (paddr == OFS_ACC0_HI)
         next_rdata = {16'h0000, acc[0][31:16]};
      else if (paddr == OFS_ACC0_LO)
         next_rdata = {16'h0000, acc[0][15:0]};
      else if (paddr == OFS_ACC1_HI)
         next_rdata = {16'h0000, acc[1][31:16]};
      else if (paddr == OFS_ACC1_LO)
         next_rdata = {16'h0000, acc[1][15:0]};
      else
         next_err = 1'b1;
   end

   // bus handshake and read data capture
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (pclk_en)
      begin
         pready <= setup;
         pslverr <= setup && next_err;
         if (setup && !pwrite)
         begin
            prdata <= next_rdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= dcsr_ctrl_t'(CTRL_RESET);
         irq_mask <= IRQ_MASK_RESET;
      end
      else if (pclk_en && wr)
      begin
         if (paddr == OFS_CTRL)
            ctrl <= dcsr_ctrl_t'(pwdata[6:0]);
         else if (paddr == OFS_IRQ_MASK)
            irq_mask <= pwdata[IRQ_W-1:0];
      end
   end

   // multiplier inputs and product
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         y <= 32'h0000_0000;
         x <= 16'h0000;
         prod <= 32'h0000_0000;
      end
      else if (pclk_en)
      begin
         if (wr && (paddr == OFS_Y_HI))
         begin
            y[31:16] <= pwdata[15:0];
            if (!ctrl.low_half_zero_inhibit[2])
            begin
               y[15:0] <= 16'h0000;
            end
         end
         else if (wr && (paddr == OFS_Y_LO))
         begin
            y[15:0] <= pwdata[15:0];
         end
         if (wr && (paddr == OFS_X))
         begin
            x <= pwdata[15:0];
         end
         if (mul_go)
         begin
            prod <= prod_scaled;
         end
      end
   end

   // accumulators; an accumulate in the same command uses the old product
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc[0] <= 36'h0_0000_0000;
         acc[1] <= 36'h0_0000_0000;
      end
      else if (pclk_en)
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (wr && (paddr == hi_ofs(i)))
            begin
               acc[i][35:16] <= {{4{pwdata[15]}}, pwdata[15:0]};
               if (!ctrl.low_half_zero_inhibit[i])
               begin
                  acc[i][15:0] <= 16'h0000;
               end
            end
            else if (wr && (paddr == lo_ofs(i)))
            begin
               acc[i][15:0] <= pwdata[15:0];
            end
            else if (wr && (paddr == OFS_PSW))
            begin
               acc[i][35:32] <= (i == 1) ? psw_wr.acc1_guard
                                         : psw_wr.acc0_guard;
            end
            else if (acc_go && (acc_dst == 1'(i)))
            begin
               acc[i] <= acc_res.value;
            end
         end
      end
   end

   // condition flags; bits 11..10 of a status write are dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags <= 4'h0;
         acc_ovf <= 2'b00;
      end
      else if (pclk_en)
      begin
         if (wr && (paddr == OFS_PSW))
         begin
            flags <= pwdata[15:12];
            acc_ovf <= {psw_wr.acc1_ovf, psw_wr.acc0_ovf};
         end
         else if (acc_go)
         begin
            flags <= {acc_res.minus, acc_res.equal, acc_res.lov,
                      acc_res.mov};
            acc_ovf[acc_dst] <= acc_res.lov;
         end
      end
   end

   // read clears only what was captured, so a later event survives
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat <= '0;
         irq <= 1'b0;
      end
      else if (pclk_en)
      begin
         if (rd && (paddr == OFS_IRQ_STAT))
            irq_stat <= (irq_stat & ~prdata[IRQ_W-1:0]) | events;
         else
            irq_stat <= irq_stat | events;
         irq <= |(irq_stat & irq_mask);
      end
   end

   sequence s_wr(logic [7:0] a);
      pclk_en && wr && (paddr == a);
   endsequence

   sequence s_acc(logic d);
      pclk_en && acc_go && (acc_dst == d);
   endsequence

   y_low_clear_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(OFS_Y_HI) |=> y[15:0] == ($past(ctrl.low_half_zero_inhibit[2])
                                    ? $past(y[15:0]) : 16'h0000))
   else $error("y low half wrong after high load");

   acc1_low_clear_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(OFS_ACC1_HI) |=> acc[1][15:0] ==
         ($past(ctrl.low_half_zero_inhibit[1]) ? $past(acc[1][15:0]) : 16'h0000))
   else $error("acc one low half wrong after high load");

   acc0_low_clear_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(OFS_ACC0_HI) |=> acc[0][15:0] ==
         ($past(ctrl.low_half_zero_inhibit[0]) ? $past(acc[0][15:0]) : 16'h0000))
   else $error("acc zero low half wrong after high load");

   high_load_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      s_wr(OFS_ACC0_HI) |=> acc[0][31:16] == $past(pwdata[15:0]))
   else $error("acc zero high half not loaded");

   acc1_clamp_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      s_acc(1'b1) ##0 !ctrl.overflow_clamp_inhibit[1] |=>
         (acc[1][35:31] == 5'h00) || (acc[1][35:31] == 5'h1F))
   else $error("acc one not saturated");

   acc0_clamp_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      s_acc(1'b0) ##0 !ctrl.overflow_clamp_inhibit[0] |=>
         (acc[0][35:31] == 5'h00) || (acc[0][35:31] == 5'h1F))
   else $error("acc zero not saturated");

   prod_div4_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      pclk_en && mul_go && (ctrl.align == DCSR_ALIGN_DIV4) |=>
         prod == 32'($past(mult_raw) >>> 2))
   else $error("product not divided by four");

   acc1_ovf_bit_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      s_acc(1'b1) ##0 acc_res.lov |=> psw_rd.acc1_ovf ##1 1'b1)
   else $error("acc one overflow bit not set");

   guard_mirror_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      pclk_en && setup && !pwrite && (paddr == OFS_PSW) |=>
         pready && (prdata[8:5] == $past(acc[1][35:32])))
   else $error("status guard bits do not mirror acc one");

   ctrl_read_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      pclk_en && setup && !pwrite && (paddr == OFS_CTRL) |=>
         (prdata[31:7] == 25'h000_0000) && (prdata[6:0] == $past(ctrl)))
   else $error("control read not zero-extended");

endmodule // dcsr_regs

// File: dau_control_status_regs_bench.sv
`timescale 1ns/100ps
module dau_control_status_regs_bench;
   import dcsr_pkg::*;

   typedef struct packed {
      logic [31:0] data;
      logic [31:0] mask;
      logic err;
   } dcsr_exp_t;

   logic pclk;
   logic presetn;
   logic pclk_en;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   dcsr_exp_t exp_q[$];
   dcsr_exp_t e;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h0000C89A;
   logic [7:0] en_lfsr = 8'hA5;
   logic [31:0] r;
   logic [7:0] hi;

   dcsr_regs uut
   (
      .pclk(pclk),
      .presetn(presetn),
      .pclk_en(pclk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .irq(irq)
   );

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task check(input string name, input logic [31:0] seen,
              input logic [31:0] want);
      comparisons++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", name, want, seen);
      end
   endtask

   task stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // stall the block now and then; every handshake must stretch with it
   always @(posedge pclk)
   begin
      en_lfsr <= {en_lfsr[6:0], en_lfsr[7] ^ en_lfsr[5] ^ en_lfsr[4]
                  ^ en_lfsr[3]};
      pclk_en <= (en_lfsr[1:0] != 2'h0) || presetn !== 1'b1;
   end

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (!(pready === 1'b1 && pclk_en === 1'b1) && i < 200);
      if (i >= 200)
      begin
         n_mismatch++;
         stop_test();
      end
      penable <= 1'b0;
      psel <= 1'b0;
      @(posedge pclk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d, input logic err = 0);
      exp_q.push_back('{32'h0, 32'h0, err});
      apb(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] m = 32'hFFFFFFFF, input logic err = 0);
      exp_q.push_back('{d, m, err});
      apb(1'b0, a, 32'h0);
   endtask

   task mul(input logic [15:0] x, input logic [15:0] y);
      wr(OFS_Y_HI, {16'h0, y});
      wr(OFS_X, {16'h0, x});
      wr(OFS_CMD, 32'h1);
   endtask

   // irq is registered, so look at it between edges
   task wait_irq(input logic lvl);
      for (int i = 0; i < 20; i++)
      begin
         @(negedge pclk);
         if (irq === lvl)
            break;
      end
      check("irq", {31'h0, irq}, {31'h0, lvl});
      @(posedge pclk);
   endtask

   always @(posedge pclk)
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
          && pclk_en === 1'b1)
      begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
         check("prdata", prdata & e.mask, e.data & e.mask);
         check("pslverr", {31'h0, pslverr}, {31'h0, e.err});
      end

   initial
   begin
      presetn = 1'b0;
      pclk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_IRQ_MASK, 32'h0);
      rd(8'hFC, 32'h0, 32'hFFFFFFFF, 1'b1);
      wr(8'hFC, 32'h1, 1'b1);
      repeat (4)
      begin
         r = rnd();
         wr(OFS_CTRL, r);
         rd(OFS_CTRL, {25'h0, r[6:0]});
      end
      // k: 0 acc zero, 1 acc one, 2 multiplier input
      for (int k = 0; k < 3; k++)
         for (int b = 0; b < 2; b++)
         begin
            hi = (k == 2) ? OFS_Y_HI : 8'(OFS_ACC0_HI + 8 * k);
            r = rnd();
            wr(OFS_CTRL, 32'(b) << (4 + k));
            wr(hi + 8'h04, {16'h0, r[15:0]});
            wr(hi, {16'h0, r[31:16]});
            rd(hi + 8'h04, b ? {16'h0, r[15:0]} : 32'h0);
            rd(hi, {16'h0, r[31:16]});
         end
      for (int a = 0; a < 3; a++)
      begin
         wr(OFS_CTRL, 32'(a));
         mul(16'h0100, 16'h0040);
         rd(OFS_PROD, a == 0 ? 32'h4000 : a == 1 ? 32'h1000 : 32'h10000);
      end
      // one accumulate of 0x40000000 onto 0x7FFF0000 overflows 32 bits
      for (int n = 0; n < 2; n++)
         for (int s = 0; s < 2; s++)
         begin
            hi = 8'(OFS_ACC0_HI + 8 * n);
            wr(OFS_CTRL, (32'(s) << (2 + n)) | 32'h2);
            mul(16'h4000, 16'h4000);
            wr(hi, 32'h7FFF);
            wr(OFS_CMD, 32'h2 | (32'(n) << 2));
            rd(hi, s ? 32'hBFFF : 32'h7FFF);
            rd(hi + 8'h04, s ? 32'h0 : 32'hFFFF);
            rd(OFS_PSW, n ? 32'h2210 : 32'h2010, n ? 32'hF3FF : 32'hF01F);
         end
      wait_irq(1'b0);
      wr(OFS_IRQ_MASK, 32'h2);
      wait_irq(1'b1);
      rd(OFS_IRQ_STAT, 32'h3);
      wait_irq(1'b0);
      rd(OFS_IRQ_STAT, 32'h0);
      r = rnd();
      wr(OFS_PSW, {16'h0, r[15:0]});
      rd(OFS_PSW, r & 32'hF3FF, 32'hF3FF);
      wr(OFS_ACC1_HI, 32'h8000);
      rd(OFS_PSW, 32'h01E0, 32'h01E0);
      // push acc zero to 0x7C0000000 so the next add overflows 36 bits
      wr(OFS_CTRL, 32'h6);
      wr(OFS_ACC0_HI, 32'hC000);
      wr(OFS_PSW, 32'h0007);
      wr(OFS_CMD, 32'h2);
      rd(OFS_PSW, 32'hB018, 32'hF3FF);
      rd(OFS_IRQ_STAT, 32'h5);
      mul(16'h0000, 16'h1234);
      wr(OFS_PROD, 32'h5A5A);
      rd(OFS_PROD, 32'h0);
      wr(OFS_ACC1_HI, 32'h0);
      wr(OFS_CMD, 32'h6);
      rd(OFS_PSW, 32'h4000, 32'hF000);
      stop_test();
   end
endmodule // dau_control_status_regs_bench
